// ### mcuih_map.vh
`ifndef MCUIH_MAP_VH
`define MCUIH_MAP_VH

// Register byte offsets
`define MCUIH_OFF_REQ1 8'h00
`define MCUIH_OFF_REQ2 8'h04
`define MCUIH_OFF_WKFLAG 8'h08
`define MCUIH_OFF_EN1 8'h0c
`define MCUIH_OFF_EN2 8'h10
`define MCUIH_OFF_WKEDGE 8'h14
`define MCUIH_OFF_EXTEDGE 8'h18
`define MCUIH_OFF_EVEDGE 8'h1c
`define MCUIH_OFF_PMODE 8'h20
`define MCUIH_OFF_CCR 8'h24
`define MCUIH_OFF_SP 8'h28
`define MCUIH_OFF_STATUS 8'h2c

// Field positions in request/enable register one, and the mask bit of CCR
`define MCUIH_BIT_PIN_A 0
`define MCUIH_BIT_PIN_B 1
`define MCUIH_BIT_EVENT 2
`define MCUIH_BIT_WAKE 3
`define MCUIH_BIT_MASK 7

// Source numbering and counts
`define MCUIH_NPER 13
`define MCUIH_NSRC 17
`define MCUIH_IDX_W 5

// Reset values and vector table base
`define MCUIH_CCR_RST 8'h80
`define MCUIH_SP_RST 16'h0000
`define MCUIH_VEC_BASE 16'h0008

// Event edge field encodings
`define MCUIH_EV_FALL 2'b00
`define MCUIH_EV_RISE 2'b01

// Entry sequence lengths, in states of one clock each
`define MCUIH_N_STACK 4
`define MCUIH_N_VEC 2
`define MCUIH_N_FETCH 4
`define MCUIH_N_INT 4

`endif

// ### mcuih_top.v
// How it works
// - Each wakeup pin edge chosen by its bit
// - All wakeup pins share one vector
// - Wakeup pin edge in interrupt-input port mode sets its flag
// - Wakeup enable bit gates shared wakeup request
// - Two request pins, own vectors, own edges
// - Request pin edge sets its flag
// - Each request pin has own enable
// - Event pin edge by two-bit field, enable-gated
// - Peripherals set flags; enable bit masks them
// - Sleep-transition flags live in request registers
// - Request forwarded only while enable is one
// - Highest priority presented, others stay pending
// - Accept only while mask bit is zero
// - After instruction, push counter and condition codes
// - Set mask after stacking; return restores codes
// - Fetch vector, load counter, start handler
// - Clearing write completes before entry begins
// - Entry: 4 stack, 2 vector, 4 fetch, 4 internal
// - Everything disabled and masked after reset
// - Word accesses force address bit zero
// - Flags cleared only by writing zero
//
// The register addresses and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "mcuih_map.vh"

module mcuih_top (
    // Clock and reset
    input wire sys_clk_in,
    input wire rst_in,
    // AHB-Lite slave
    input wire hsel_in,
    input wire [7:0] haddr_in,
    input wire [1:0] htrans_in,
    input wire hwrite_in,
    input wire [2:0] hsize_in,
    input wire [31:0] hwdata_in,
    input wire hready_in,
    output wire hreadyout_out,
    output wire hresp_out,
    output reg [31:0] hrdata_out,
    // External pins
    input wire [7:0] wakeup_pins_in,
    input wire ext_request_pin_a_in,
    input wire ext_request_pin_b_in,
    input wire event_counter_request_pin_in,
    // Peripheral request pulses
    input wire [`MCUIH_NPER-1:0] periph_req_in,
    // CPU core
    input wire instr_done_in,
    input wire [15:0] next_pc_in,
    input wire rti_in,
    input wire [7:0] ccr_restore_in,
    input wire [15:0] mem_rdata_in,
    output reg mem_wr_out,
    output reg mem_rd_out,
    output reg [15:0] mem_addr_out,
    output reg [15:0] mem_wdata_out,
    output reg pc_load_out,
    output reg [15:0] pc_out,
    output reg exc_busy_out,
    output reg irq_pending_out
);

    localparam ST_IDLE = 3'd0;
    localparam ST_STACK = 3'd1;
    localparam ST_VEC = 3'd2;
    localparam ST_FETCH = 3'd3;
    localparam ST_INT = 3'd4;

    // Bus state
    reg ap_wr_q;
    reg [7:0] ap_addr_q;
    wire ap_take;
    wire wr_now;

    // Register file
    reg [7:0] req1_q;
    reg [7:0] req2_q;
    reg [7:0] wkflag_q;
    reg [7:0] en1_q;
    reg [7:0] en2_q;
    reg [7:0] wkedge_q;
    reg [1:0] extedge_q;
    reg [1:0] evedge_q;
    reg [9:0] pmode_q;
    reg [7:0] ccr_q;
    reg [15:0] sp_q;

    // Pin synchronisers and edge history
    reg [10:0] pin_s1_q;
    reg [10:0] pin_s2_q;
    reg [10:0] pin_prev_q;
    wire [10:0] rise;
    wire [10:0] fall;
    wire [7:0] wk_set;
    wire pa_set;
    wire pb_set;
    wire ev_set;
    reg ev_edge;

    // Sequencer
    reg [2:0] state_q;
    reg [3:0] cnt_q;
    reg [`MCUIH_IDX_W-1:0] src_q;
    reg [15:0] saved_pc_q;
    reg [15:0] vec_data_q;

    // Request gating and priority
    wire [`MCUIH_NSRC-1:0] flags;
    wire [`MCUIH_NSRC-1:0] enables;
    wire [`MCUIH_NSRC-1:0] live;
    reg [`MCUIH_IDX_W-1:0] top_idx;
    reg top_valid;
    integer i;

    // Flag set and clear terms
    wire [7:0] req1_set;
    wire [7:0] req2_set;
    wire req1_clr;
    wire req2_clr;
    wire wk_clr;

    // Entry qualifiers and addresses
    wire mask_on;
    wire accept;
    wire stack_wr;
    wire [15:0] push_addr;
    wire [15:0] vec_addr;

    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign ap_take = hsel_in && hready_in && htrans_in[1];
    assign wr_now = ap_wr_q;

    // Set terms from pins and peripherals, clear terms from bus writes
    assign req1_set = {periph_req_in[4:0], ev_set, pb_set, pa_set};
    assign req2_set = periph_req_in[12:5];
    assign req1_clr = wr_now && (ap_addr_q == `MCUIH_OFF_REQ1);
    assign req2_clr = wr_now && (ap_addr_q == `MCUIH_OFF_REQ2);
    assign wk_clr = wr_now && (ap_addr_q == `MCUIH_OFF_WKFLAG);

    // Entry waits out a write data phase so a clear lands first
    assign mask_on = ccr_q[`MCUIH_BIT_MASK];
    assign accept = instr_done_in && top_valid && !mask_on && !wr_now && !rti_in;
    assign stack_wr = (state_q == ST_STACK) && !cnt_q[0];
    assign push_addr = {sp_q[15:1], 1'b0} - 16'h0002;
    assign vec_addr = `MCUIH_VEC_BASE + {10'h000, src_q, 1'b0};

    // Synchronise then compare with previous sample
    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            pin_s1_q <= 11'h7ff;
            pin_s2_q <= 11'h7ff;
            pin_prev_q <= 11'h7ff;
        end else begin
            pin_s1_q <= {event_counter_request_pin_in, ext_request_pin_b_in, ext_request_pin_a_in, wakeup_pins_in};
            pin_s2_q <= pin_s1_q;
            pin_prev_q <= pin_s2_q;
        end
    end

    assign rise = pin_s2_q & ~pin_prev_q;
    assign fall = ~pin_s2_q & pin_prev_q;

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_wake
            // Edge per pin, only in interrupt-input port mode
            assign wk_set[g] = pmode_q[2 + g] && (wkedge_q[g] ? rise[g] : fall[g]);
        end
    endgenerate

    assign pa_set = pmode_q[0] && (extedge_q[0] ? rise[8] : fall[8]);
    assign pb_set = pmode_q[1] && (extedge_q[1] ? rise[9] : fall[9]);

    always @* begin
        case (evedge_q)
            `MCUIH_EV_FALL: ev_edge = fall[10];
            `MCUIH_EV_RISE: ev_edge = rise[10];
            default: ev_edge = rise[10] | fall[10];
        endcase
    end
    assign ev_set = ev_edge && en1_q[`MCUIH_BIT_EVENT];

    // Bus address phase capture and read data
    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            ap_wr_q <= 1'b0;
            ap_addr_q <= 8'h00;
            hrdata_out <= 32'h00000000;
        end else begin
            ap_wr_q <= ap_take && hwrite_in;
            if (ap_take) begin
                ap_addr_q <= {haddr_in[7:2], 2'b00};
            end
            if (ap_take && !hwrite_in) begin
                case ({haddr_in[7:2], 2'b00})
                    `MCUIH_OFF_REQ1: hrdata_out <= {24'h000000, req1_q};
                    `MCUIH_OFF_REQ2: hrdata_out <= {24'h000000, req2_q};
                    `MCUIH_OFF_WKFLAG: hrdata_out <= {24'h000000, wkflag_q};
                    `MCUIH_OFF_EN1: hrdata_out <= {24'h000000, en1_q};
                    `MCUIH_OFF_EN2: hrdata_out <= {24'h000000, en2_q};
                    `MCUIH_OFF_WKEDGE: hrdata_out <= {24'h000000, wkedge_q};
                    `MCUIH_OFF_EXTEDGE: hrdata_out <= {30'h0, extedge_q};
                    `MCUIH_OFF_EVEDGE: hrdata_out <= {30'h0, evedge_q};
                    `MCUIH_OFF_PMODE: hrdata_out <= {22'h0, pmode_q};
                    `MCUIH_OFF_CCR: hrdata_out <= {24'h000000, ccr_q};
                    `MCUIH_OFF_SP: hrdata_out <= {16'h0000, sp_q};
                    `MCUIH_OFF_STATUS: hrdata_out <= {16'h0000, 2'b00, top_valid, src_q, exc_busy_out, state_q, 4'h0};
                    default: hrdata_out <= 32'h00000000;
                endcase
            end
        end
    end

    // Request flags: zero clears, one keeps, hardware set wins
    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            req1_q <= 8'h00;
            req2_q <= 8'h00;
            wkflag_q <= 8'h00;
        end else begin
            req1_q <= (req1_clr ? (req1_q & hwdata_in[7:0]) : req1_q)
                | req1_set;
            req2_q <= (req2_clr ? (req2_q & hwdata_in[7:0]) : req2_q)
                | req2_set;
            wkflag_q <= (wk_clr ? (wkflag_q & hwdata_in[7:0]) : wkflag_q)
                | wk_set;
        end
    end

    // Control registers; all enables off after reset
    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            en1_q <= 8'h00;
            en2_q <= 8'h00;
            wkedge_q <= 8'h00;
            extedge_q <= 2'b00;
            evedge_q <= 2'b00;
            pmode_q <= 10'h000;
            sp_q <= `MCUIH_SP_RST;
        end else begin
            if (wr_now) begin
                case (ap_addr_q)
                    `MCUIH_OFF_EN1: en1_q <= hwdata_in[7:0];
                    `MCUIH_OFF_EN2: en2_q <= hwdata_in[7:0];
                    `MCUIH_OFF_WKEDGE: wkedge_q <= hwdata_in[7:0];
                    `MCUIH_OFF_EXTEDGE: extedge_q <= hwdata_in[1:0];
                    `MCUIH_OFF_EVEDGE: evedge_q <= hwdata_in[1:0];
                    `MCUIH_OFF_PMODE: pmode_q <= hwdata_in[9:0];
                    default: en1_q <= en1_q;
                endcase
            end
            // Bus write to the stack pointer beats stacking and return
            if (wr_now && ap_addr_q == `MCUIH_OFF_SP) begin
                sp_q <= {hwdata_in[15:1], 1'b0};
            end else if (stack_wr) begin
                sp_q <= sp_q - 16'h0002;
            end else if (rti_in) begin
                sp_q <= sp_q + 16'h0004;
            end
        end
    end

    // Sources in priority order, index zero highest
    assign flags = {req2_q, req1_q[7:3], |wkflag_q, req1_q[2:0]};
    assign enables = {en2_q, en1_q[7:3], en1_q[`MCUIH_BIT_WAKE], en1_q[2:0]};
    assign live = flags & enables;

    always @* begin
        top_idx = {`MCUIH_IDX_W{1'b0}};
        top_valid = 1'b0;
        for (i = `MCUIH_NSRC - 1; i >= 0; i = i - 1) begin
            if (live[i]) begin
                top_idx = i[`MCUIH_IDX_W-1:0];
                top_valid = 1'b1;
            end
        end
    end

    // Entry sequencer
    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
            src_q <= {`MCUIH_IDX_W{1'b0}};
            saved_pc_q <= 16'h0000;
            vec_data_q <= 16'h0000;
            ccr_q <= `MCUIH_CCR_RST;
            mem_wr_out <= 1'b0;
            mem_rd_out <= 1'b0;
            mem_addr_out <= 16'h0000;
            mem_wdata_out <= 16'h0000;
            pc_load_out <= 1'b0;
            pc_out <= 16'h0000;
            exc_busy_out <= 1'b0;
            irq_pending_out <= 1'b0;
        end else begin
            mem_wr_out <= 1'b0;
            mem_rd_out <= 1'b0;
            pc_load_out <= 1'b0;
            irq_pending_out <= top_valid && !mask_on;
            if (wr_now && ap_addr_q == `MCUIH_OFF_CCR) begin
                ccr_q <= hwdata_in[7:0];
            end else if (rti_in && state_q == ST_IDLE) begin
                ccr_q <= ccr_restore_in;
            end
            case (state_q)
                ST_IDLE: begin
                    if (accept) begin
                        state_q <= ST_STACK;
                        cnt_q <= 4'h0;
                        src_q <= top_idx;
                        saved_pc_q <= next_pc_in;
                        exc_busy_out <= 1'b1;
                    end
                end
                ST_STACK: begin
                    if (stack_wr) begin
                        mem_wr_out <= 1'b1;
                        mem_addr_out <= push_addr;
                        mem_wdata_out <= (cnt_q == 4'h0) ? saved_pc_q : {ccr_q, ccr_q};
                    end
                    if (cnt_q == `MCUIH_N_STACK - 1) begin
                        ccr_q[`MCUIH_BIT_MASK] <= 1'b1;
                        state_q <= ST_VEC;
                        cnt_q <= 4'h0;
                    end else begin
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
                ST_VEC: begin
                    if (cnt_q == 4'h0) begin
                        mem_rd_out <= 1'b1;
                        mem_addr_out <= vec_addr;
                    end
                    if (cnt_q == `MCUIH_N_VEC - 1) begin
                        vec_data_q <= {mem_rdata_in[15:1], 1'b0};
                        state_q <= ST_FETCH;
                        cnt_q <= 4'h0;
                    end else begin
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
                ST_FETCH: begin
                    if (cnt_q == `MCUIH_N_FETCH - 1) begin
                        state_q <= ST_INT;
                        cnt_q <= 4'h0;
                    end else begin
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
                ST_INT: begin
                    if (cnt_q == `MCUIH_N_INT - 1) begin
                        pc_load_out <= 1'b1;
                        pc_out <= vec_data_q;
                        exc_busy_out <= 1'b0;
                        state_q <= ST_IDLE;
                        cnt_q <= 4'h0;
                    end else begin
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    cnt_q <= 4'h0;
                end
            endcase
        end
    end

endmodule // mcuih_top
`default_nettype wire

// ### mcuih_blank_guard.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### mcuih_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module mcuih_monitor (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // Watched ports
    input wire logic [15:0] next_pc_in,
    input wire logic mem_wr_out,
    input wire logic mem_rd_out,
    input wire logic [15:0] mem_addr_out,
    input wire logic [15:0] mem_wdata_out,
    input wire logic pc_load_out,
    input wire logic [15:0] pc_out,
    input wire logic exc_busy_out,
    input wire logic irq_pending_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    reset_quiet_a: assert property ($fell(rst_in) |-> !irq_pending_out && !exc_busy_out)
        else $error("entry logic active after reset");
    stack_pc_a: assert property ($rose(exc_busy_out) |=> mem_wr_out && mem_wdata_out == $past(next_pc_in, 2))
        else $error("return address not stacked first");
    ccr_push_a: assert property ($rose(exc_busy_out) |-> ##1 mem_wr_out ##1 !mem_wr_out
        ##1 mem_wr_out && mem_wdata_out[15:8] == mem_wdata_out[7:0] && mem_addr_out == $past(mem_addr_out, 2) - 16'h0002)
        else $error("condition codes not stacked below return address");
    vec_read_a: assert property ($rose(exc_busy_out) |-> ##5 mem_rd_out && mem_addr_out >= 16'h0008
        && mem_addr_out < 16'h002a) else $error("vector read missing or out of table");
    word_align_a: assert property ((mem_wr_out || mem_rd_out) |-> !mem_addr_out[0])
        else $error("odd word address");
    entry_len_a: assert property ($rose(exc_busy_out) |-> ##14 pc_load_out)
        else $error("handler start not at fixed entry length");
    busy_hold_a: assert property ($rose(exc_busy_out) |-> exc_busy_out [*8] ##0 !pc_load_out)
        else $error("entry sequence cut short");
    handler_load_a: assert property (pc_load_out |-> !exc_busy_out && $past(exc_busy_out) && !pc_out[0])
        else $error("handler load outside entry");
    entry_cv: cover property ($rose(exc_busy_out));
    vector_cv: cover property (mem_rd_out);
    handler_cv: cover property (pc_load_out);
endmodule // mcuih_monitor
bind mcuih_top mcuih_monitor mon_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .next_pc_in(next_pc_in),
    .mem_wr_out(mem_wr_out), .mem_rd_out(mem_rd_out), .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
    .pc_load_out(pc_load_out), .pc_out(pc_out), .exc_busy_out(exc_busy_out), .irq_pending_out(irq_pending_out));
`default_nettype wire

// ### mcuih_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module mcuih_cpu_model (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // Entry sequence from the controller
    input wire logic mem_rd_in,
    input wire logic [15:0] mem_addr_in,
    input wire logic pc_load_in,
    input wire logic [15:0] pc_in,
    // Core side
    output logic instr_done_out,
    output logic [15:0] next_pc_out,
    output logic [15:0] mem_rdata_out,
    // Handler starts seen
    output logic [15:0] handler_pc_out,
    output logic [7:0] loads_out
);
    logic [1:0] phase_q;
    logic [15:0] noise_q;
    // Vector table answers at once; otherwise a changing pattern
    assign mem_rdata_out = mem_rd_in ? (16'h4000 | {mem_addr_in[11:0], 4'h0}) : noise_q;
    always @(posedge sys_clk_in) begin
        if (rst_in) begin
            phase_q <= 2'h0;
            instr_done_out <= 1'b0;
            next_pc_out <= 16'h0200;
            noise_q <= 16'h5a5a;
            loads_out <= 8'h00;
            handler_pc_out <= 16'h0000;
        end else begin
            phase_q <= phase_q + 2'h1;
            instr_done_out <= (phase_q == 2'h3);
            next_pc_out <= next_pc_out + 16'h0002;
            noise_q <= ~noise_q;
            if (pc_load_in) begin
                loads_out <= loads_out + 8'h01;
                handler_pc_out <= pc_in;
            end
        end
    end
endmodule // mcuih_cpu_model
`default_nettype wire

// ### mcu_interrupt_handling_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mcu_interrupt_handling_tb;
    logic sys_clk_in = 1'b0, rst_in = 1'b1, hsel_in = 1'b0, hwrite_in = 1'b0, rti_in = 1'b0;
    logic pin_a = 1'b1, pin_b = 1'b1, event_pin = 1'b1;
    logic [1:0] htrans_in = 2'h0;
    logic [7:0] haddr_in = 8'h00, wakeup_pins_in = 8'hff, ccr_restore_in = 8'h00;
    logic [31:0] hwdata_in = 32'h0, rd;
    logic [12:0] periph_req_in = 13'h0;
    wire hreadyout_out, hresp_out, mem_wr_out, mem_rd_out, pc_load_out, exc_busy_out, irq_pending_out, instr_done_in;
    wire [31:0] hrdata_out;
    wire [15:0] mem_addr_out, mem_wdata_out, pc_out, next_pc_in, mem_rdata_in, handler_pc;
    wire [7:0] loads;
    int mismatches = 0, num_checks = 0;
    always #5 sys_clk_in = ~sys_clk_in;
    mcuih_top dut_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
        .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2), .hwdata_in(hwdata_in),
        .hready_in(hreadyout_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .hrdata_out(hrdata_out),
        .wakeup_pins_in(wakeup_pins_in), .ext_request_pin_a_in(pin_a), .ext_request_pin_b_in(pin_b),
        .event_counter_request_pin_in(event_pin), .periph_req_in(periph_req_in), .instr_done_in(instr_done_in),
        .next_pc_in(next_pc_in), .rti_in(rti_in), .ccr_restore_in(ccr_restore_in), .mem_rdata_in(mem_rdata_in),
        .mem_wr_out(mem_wr_out), .mem_rd_out(mem_rd_out), .mem_addr_out(mem_addr_out),
        .mem_wdata_out(mem_wdata_out), .pc_load_out(pc_load_out), .pc_out(pc_out), .exc_busy_out(exc_busy_out),
        .irq_pending_out(irq_pending_out));
    mcuih_cpu_model cpu_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .mem_rd_in(mem_rd_out),
        .mem_addr_in(mem_addr_out), .pc_load_in(pc_load_out), .pc_in(pc_out), .instr_done_out(instr_done_in),
        .next_pc_out(next_pc_in), .mem_rdata_out(mem_rdata_in), .handler_pc_out(handler_pc), .loads_out(loads));
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One single AHB transfer, address phase then data phase
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge sys_clk_in);
        hsel_in <= 1'b1;
        haddr_in <= a;
        hwrite_in <= wr;
        htrans_in <= 2'h2;
        @(posedge sys_clk_in);
        while (hreadyout_out !== 1'b1) @(posedge sys_clk_in);
        hsel_in <= 1'b0;
        htrans_in <= 2'h0;
        hwdata_in <= d;
        @(posedge sys_clk_in);
        while (hreadyout_out !== 1'b1) @(posedge sys_clk_in);
        q = hrdata_out;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, rd);
    endtask
    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, rd);
        chk(what, exp, rd);
    endtask
    task automatic settle;
        repeat (6) @(posedge sys_clk_in);
    endtask
    task automatic pulse_event;
        event_pin <= 1'b0;
        settle();
        event_pin <= 1'b1;
        settle();
    endtask
    task automatic rti(input logic [7:0] c);
        @(posedge sys_clk_in);
        rti_in <= 1'b1;
        ccr_restore_in <= c;
        @(posedge sys_clk_in);
        rti_in <= 1'b0;
    endtask
    task automatic handler(input logic [7:0] n, input logic [15:0] pc);
        for (int i = 0; i < 300 && loads < n; i++) @(posedge sys_clk_in);
        chk("handler starts", {24'h0, n}, {24'h0, loads});
        chk("handler address", {16'h0, pc}, {16'h0, handler_pc});
    endtask
    initial begin
        #200000;
        mismatches++;
        $display("mismatch watchdog expected done seen hang");
        final_report();
    end
    initial begin
        repeat (3) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        rdchk("ccr", 8'h24, 32'h80);
        rdchk("enable one", 8'h0c, 32'h0);
        chk("bus response", 32'h0, {31'h0, hresp_out});
        wr(8'h00, 32'hff);
        rdchk("request one", 8'h00, 32'h0);
        rdchk("unmapped", 8'h3c, 32'h0);
        wr(8'h20, 32'h3ff);
        wr(8'h14, 32'haa);
        wakeup_pins_in <= 8'h00;
        settle();
        rdchk("wakeup flags", 8'h08, 32'h55);
        wakeup_pins_in <= 8'hff;
        settle();
        rdchk("wakeup flags", 8'h08, 32'hff);
        wr(8'h1c, 32'h1);
        pulse_event();
        rdchk("event blocked", 8'h00, 32'h0);
        wr(8'h0c, 32'h4);
        pulse_event();
        rdchk("event flag", 8'h00, 32'h4);
        wr(8'h00, 32'hfb);
        @(posedge sys_clk_in);
        periph_req_in <= 13'h20;
        @(posedge sys_clk_in);
        periph_req_in <= 13'h0;
        settle();
        rdchk("request two", 8'h04, 32'h1);
        wr(8'h04, 32'h0);
        rdchk("request two", 8'h04, 32'h0);
        wr(8'h0c, 32'h3);
        wr(8'h28, 32'h100);
        pin_a <= 1'b0;
        pin_b <= 1'b0;
        settle();
        rdchk("pin flags", 8'h00, 32'h3);
        chk("pending while masked", 32'h0, {31'h0, irq_pending_out});
        wr(8'h24, 32'h0);
        handler(8'h1, 16'h4080);
        rdchk("ccr", 8'h24, 32'h80);
        rdchk("stack pointer", 8'h28, 32'hfc);
        wr(8'h00, 32'hfe);
        rdchk("request one", 8'h00, 32'h2);
        rti(8'h00);
        handler(8'h2, 16'h40a0);
        wr(8'h00, 32'h0);
        rti(8'h00);
        settle();
        rdchk("ccr", 8'h24, 32'h0);
        chk("wakeup blocked", 32'h0, {31'h0, irq_pending_out});
        wr(8'h0c, 32'h8);
        handler(8'h3, 16'h40e0);
        final_report();
    end
endmodule // mcu_interrupt_handling_tb
`default_nettype wire
